// ==== bench/lvr_monitor.sv ====
// monitor: concurrent checks on the frame link between host and device
`timescale 1ns/1ps
module lvr_monitor
  import lvr_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // frame link
  input wire logic        req,
  input wire logic [15:0] frame,
  input wire logic        rsp,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a read frame with its decoded address
  wire rd_req = req && !frame[CMD_BIT];
  wire [4:0] adr = frame[14:10];

  property p_rsp_next; req |=> rsp; endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("frame not answered");
  property p_rsp_cause; rsp |-> $past(req); endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without frame");
  property p_key_zero; rd_req && adr == ADDR_RST_KEY |=> rdata[8:0] == 9'h000; endproperty
  a_key_zero: assert property (p_key_zero) else $error("key reads nonzero");
  property p_unmap_zero; rd_req && adr > ADDR_LAST |=> rdata[8:0] == 9'h000; endproperty
  a_unmap_zero: assert property (p_unmap_zero) else $error("unmapped nonzero");
  property p_odd; req |-> ^frame; endproperty
  a_odd: assert property (p_odd) else $error("frame parity even");
  property p_rd_data; rd_req |-> frame[8:0] == 9'h000; endproperty
  a_rd_data: assert property (p_rd_data) else $error("read frame data set");
  property p_echo; rd_req |=> rdata[14:10] == $past(adr); endproperty
  a_echo: assert property (p_echo) else $error("address echo wrong");
  // answer word is held between answers
  property p_hold; !rsp |-> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("answer word moved");

  c_write: cover property (req && frame[CMD_BIT]);
  c_key_read: cover property (rd_req && adr == ADDR_RST_KEY);
  c_value: cover property (rsp && rdata[8:0] != 9'h000);
endmodule : lvr_monitor

// ==== bench/lvr_test.sv ====
// bench: host and device ends joined by the link, driven over apb
`timescale 1ns/1ps
module lvr_test
  import lvr_pkg::*;
;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
  // clock, reset and apb
  logic pclk = 0, presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr;
  // converter side of the device
  logic cdn = 0, cst = 0, cch = 0, dim1 = 0, dim2 = 0;
  logic [7:0] ccode = 8'h00;
  wire perr, srst;
  logic seen_srst = 0;
  logic [31:0] rword;
  int n_mismatch = 0, n_compared = 0;
  lvr_link_if link();

  always #50 pclk = ~pclk;
  // soft reset pulse is one cycle, so latch it
  always @(posedge pclk) if (srst === 1'b1) seen_srst <= 1'b1;

  lvr_host i_lvr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  lvr_device i_lvr_device (.pclk(pclk), .presetn(presetn), .link(link), .conv_done(cdn),
    .conv_code(ccode), .conv_start(cst), .ch1_dim_input(dim1), .ch2_dim_input(dim2),
    .conv_ch(cch), .parity_err(perr), .soft_reset(srst));
  lvr_monitor i_lvr_monitor (.pclk(pclk), .presetn(presetn), .req(link.req),
    .frame(link.frame), .rsp(link.rsp), .rdata(link.rdata));

  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // one apb transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // launch a frame, poll busy, fetch the answer value
  task automatic acc(input logic w, input logic [4:0] a, input logic [8:0] d,
                     output logic [8:0] v);
    logic [31:0] r;
    int k;
    apb(1'b1, HOST_CTRL, {16'h0000, w, a, 1'b0, d}, r);
    k = 0;
    do begin
      apb(1'b0, HOST_STAT, 32'h0000_0000, r);
      k++;
    end while (r[0] !== 1'b0 && k < 40);
    `CHK(r[0], 1'b0)
    `CHK(perr, 1'b0)
    apb(1'b0, HOST_RDATA, 32'h0000_0000, r);
    v = r[8:0];
  endtask : acc

  task automatic rd(input logic [4:0] a, input logic [8:0] e);
    logic [8:0] v;
    // host must drop the data field of a read frame
    acc(1'b0, a, 9'h1FF, v);
    `CHK(v, e)
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [8:0] d);
    logic [8:0] v;
    acc(1'b1, a, d, v);
  endtask : wr

  // one conversion: start latches the dim level, done delivers the code
  task automatic conv(input logic ch, input logic [7:0] code);
    @(posedge pclk);
    cch <= ch;
    cst <= 1'b1;
    @(posedge pclk);
    cst <= 1'b0;
    cdn <= 1'b1;
    ccode <= code;
    @(posedge pclk);
    cdn <= 1'b0;
  endtask : conv

  task automatic dim(input logic ch, input logic v);
    @(posedge pclk);
    if (ch) dim2 <= v;
    else dim1 <= v;
    repeat (2) @(posedge pclk);
  endtask : dim

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 12; i <= 16; i++) rd(i[4:0], 9'h000);
    conv(1'b1, 8'h5A);
    rd(ADDR_CH2_LAT, 9'h05A);
    dim(1'b1, 1'b1);
    rd(ADDR_CH2_OFF, 9'h05A);
    conv(1'b1, 8'hA7);
    rd(ADDR_CH2_LAT, 9'h1A7);
    dim(1'b1, 1'b0);
    rd(ADDR_CH2_ON, 9'h0A7);
    rd(ADDR_CH2_OFF, 9'h05A);
    conv(1'b0, 8'h33);
    dim(1'b0, 1'b1);
    conv(1'b0, 8'h44);
    dim(1'b0, 1'b0);
    rd(ADDR_CH1_OFF, 9'h033);
    rd(ADDR_CH1_LAT, 9'h144);
    rd(ADDR_CH1_ON, 9'h044);
    wr(ADDR_CH2_OFF, 9'h1FF);
    rd(ADDR_CH2_OFF, 9'h05A);
    wr(ADDR_RST_KEY, 9'h0C2);
    rd(ADDR_CH2_ON, 9'h0A7);
    `CHK(seen_srst, 1'b0)
    wr(ADDR_RST_KEY, RESET_KEY);
    `CHK(seen_srst, 1'b1)
    apb(1'b0, HOST_CTRL, 32'h0000_0000, rword);
    `CHK(rword, 32'h0000_C2C3)
    rd(ADDR_CH2_ON, 9'h000);
    rd(ADDR_CH2_OFF, 9'h000);
    rd(ADDR_CH1_OFF, 9'h000);
    rd(ADDR_RST_KEY, 9'h000);
    apb(1'b0, HOST_CTRL, 32'h0000_0000, rword);
    `CHK(rword, 32'h0000_4000)
    rd(ADDR_CH2_LAT, 9'h1A7);
    rd(5'h11, 9'h000);
    rd(5'h1F, 9'h000);
    // power-on clear in mid-run, latest samples included
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CH2_LAT, 9'h000);
    rd(ADDR_CH1_LAT, 9'h000);
    final_report();
  end
endmodule : lvr_test

// ==== shared/lvr_link_if.sv ====
// interface: word-level command frame link between host and device
`timescale 1ns/1ps
interface lvr_link_if;
  logic        req;   // host presents a frame, one cycle pulse
  logic [15:0] frame; // command frame, valid with req
  logic        rsp;   // device answers, one cycle pulse
  logic [15:0] rdata; // response word, valid with rsp

  modport device (input req, input frame, output rsp, output rdata);
  modport host   (output req, output frame, input rsp, input rdata);
endinterface : lvr_link_if

// ==== shared/lvr_pkg.sv ====
// package: frame layout, register map and reset values for the led voltage read-back bank
package lvr_pkg;
  // command frame layout
  localparam int unsigned FRAME_W      = 16;
  localparam int unsigned CMD_BIT      = 15;
  localparam int unsigned ADDR_LSB     = 10;
  localparam int unsigned ADDR_W       = 5;
  localparam int unsigned PAR_BIT      = 9;
  localparam int unsigned DATA_W       = 9;
  localparam int unsigned SAMPLE_W     = 8;
  localparam int unsigned LEVEL_BIT    = 8;
  // register offsets, in frame address units
  localparam logic [4:0]  ADDR_LAST    = 5'h10;
  localparam logic [4:0]  ADDR_CH1_LAT = 5'h0A;
  localparam logic [4:0]  ADDR_CH1_ON  = 5'h0B;
  localparam logic [4:0]  ADDR_CH1_OFF = 5'h0C;
  localparam logic [4:0]  ADDR_CH2_LAT = 5'h0D;
  localparam logic [4:0]  ADDR_CH2_ON  = 5'h0E;
  localparam logic [4:0]  ADDR_CH2_OFF = 5'h0F;
  localparam logic [4:0]  ADDR_RST_KEY = 5'h10;
  // key value and reset values
  localparam logic [8:0]  RESET_KEY    = 9'h0C3;
  localparam logic [8:0]  SAMPLE_RST   = 9'h000;
  // host apb register offsets (byte addresses)
  localparam logic [7:0]  HOST_CTRL    = 8'h00;
  localparam logic [7:0]  HOST_STAT    = 8'h04;
  localparam logic [7:0]  HOST_RDATA   = 8'h08;

  // odd parity bit for the 15 frame bits other than bit 9
  function automatic logic lvr_parity(input logic [15:0] f);
    logic [15:0] m;
    m = f;
    m[PAR_BIT] = 1'b0;
    lvr_parity = ~(^m);
  endfunction : lvr_parity
endpackage : lvr_pkg

// ==== verilog/lvr_device.sv ====
// device end: led voltage sample registers, soft reset key and frame decode
// Functional notes
// - per channel keep sample before dim rise
// - sample scale is 0.26 volt per lsb
// - ch2 latest: code bits 7-0, dim bit 8
// - ch2 captures sample before dim falling edge
// - ch2 captures sample before dim rising edge
// - writing 0x0C3 to key restores defaults; code clears the on and off samples only, latest samples are kept
// - key register reads back as zero
// - frame bit 15 one means write
// - address sits in frame bits 14 to 10
// - write data in bits 8-0, reads zero
// - bit 9 makes frame ones count odd
// - decode addresses 0x0A through 0x10
// - latest updates on every conversion, unsynchronised
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module lvr_device
  import lvr_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // frame link
  lvr_link_if.device       link,
  // converter side
  input  wire logic        conv_done,
  input  wire logic [7:0]  conv_code,
  input  wire logic        conv_start,
  input  wire logic        ch1_dim_input,
  input  wire logic        ch2_dim_input,
  input  wire logic        conv_ch,
  // status
  output logic             parity_err,
  output logic             soft_reset
);
  // all device state
  typedef struct packed {
    logic [1:0] dim_q;     // previous dim levels, for edge detection
    logic [1:0] lvl_st;    // dim level at conversion start per channel
    logic [8:0] ch1_lat;   // ch1 latest code plus level
    logic [7:0] ch1_on;    // ch1 sample before falling edge
    logic [7:0] ch1_off;   // ch1 sample before rising edge
    logic [8:0] ch2_lat;   // ch2 latest code plus level
    logic [7:0] ch2_on;    // ch2 sample before falling edge
    logic [7:0] ch2_off;   // ch2 sample before rising edge
    logic       rsp;       // answer pulse
    logic [15:0] rdata;    // answer word
    logic       perr;      // last frame had bad parity
    logic       srst;      // soft reset pulse
  } lvr_dev_s;

  lvr_dev_s st_r;          // registered state
  lvr_dev_s st_nxt;        // next state

  logic       wr;          // decoded write flag
  logic [4:0] addr;        // decoded address
  logic [8:0] wdat;        // decoded write data
  logic [8:0] rd_val;      // register read value
  logic       par_ok;      // frame parity good

  // frame field decode
  always_comb
  begin
    wr     = link.frame[CMD_BIT];
    addr   = link.frame[ADDR_LSB +: ADDR_W];
    wdat   = link.frame[DATA_W-1:0];
    par_ok = ^link.frame;
  end

  // read mux; codes are raw adc counts at 0.26 volt per lsb
  always_comb
  begin
    rd_val = '0;
    unique case (addr)
      ADDR_CH1_LAT: rd_val = st_r.ch1_lat;
      ADDR_CH1_ON:  rd_val = {1'b0, st_r.ch1_on};
      ADDR_CH1_OFF: rd_val = {1'b0, st_r.ch1_off};
      ADDR_CH2_LAT: rd_val = st_r.ch2_lat;
      ADDR_CH2_ON:  rd_val = {1'b0, st_r.ch2_on};
      ADDR_CH2_OFF: rd_val = {1'b0, st_r.ch2_off};
      ADDR_RST_KEY: rd_val = '0;
      // other converter registers live elsewhere and read zero here
      default:      rd_val = '0;
    endcase
  end

  // next state
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.rsp  = 1'b0;
    st_nxt.srst = 1'b0;
    st_nxt.dim_q = {ch2_dim_input, ch1_dim_input};
    // remember dim level when each conversion starts
    if (conv_start)
    begin
      st_nxt.lvl_st[conv_ch] = conv_ch ? ch2_dim_input : ch1_dim_input;
    end
    if (conv_done)
    begin
      if (conv_ch)
      begin
        st_nxt.ch2_lat = {st_r.lvl_st[1], conv_code};
      end
      else
      begin
        st_nxt.ch1_lat = {st_r.lvl_st[0], conv_code};
      end
    end
    if (ch1_dim_input && !st_r.dim_q[0])
    begin
      st_nxt.ch1_off = st_r.ch1_lat[7:0];
    end
    // falling edge of ch1 keeps the on sample
    if (!ch1_dim_input && st_r.dim_q[0])
    begin
      st_nxt.ch1_on = st_r.ch1_lat[7:0];
    end
    if (ch2_dim_input && !st_r.dim_q[1])
    begin
      st_nxt.ch2_off = st_r.ch2_lat[7:0];
    end
    if (!ch2_dim_input && st_r.dim_q[1])
    begin
      st_nxt.ch2_on = st_r.ch2_lat[7:0];
    end
    // frame handling; a frame with bad parity is answered but not acted on
    if (link.req)
    begin
      st_nxt.rsp   = 1'b1;
      st_nxt.perr  = !par_ok;
      st_nxt.rdata = '0;
      if (par_ok && !wr)
      begin
        st_nxt.rdata[DATA_W-1:0] = rd_val;
        st_nxt.rdata[ADDR_LSB +: ADDR_W] = addr;
      end
      if (par_ok && wr && addr == ADDR_RST_KEY && wdat == RESET_KEY)
      begin
        st_nxt.srst = 1'b1;
        st_nxt.ch1_on  = SAMPLE_RST[7:0];
        st_nxt.ch1_off = SAMPLE_RST[7:0];
        st_nxt.ch2_on  = SAMPLE_RST[7:0];
        st_nxt.ch2_off = SAMPLE_RST[7:0];
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign link.rsp   = st_r.rsp;
  assign link.rdata = st_r.rdata;
  assign parity_err = st_r.perr;
  assign soft_reset = st_r.srst;
endmodule : lvr_device

// ==== verilog/lvr_host.sv ====
// host end: apb slave that builds command frames and returns answers
`timescale 1ns/1ps
module lvr_host
  import lvr_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // frame link
  lvr_link_if.host         link
);
  // state encodings
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } lvr_hst_e;

  typedef struct packed {
    lvr_hst_e    fsm;     // idle or waiting for answer
    logic        req;     // request pulse
    logic [15:0] frame;   // frame sent
    logic [15:0] rword;   // last answer
    logic [31:0] prd;     // apb read data
  } lvr_host_s;

  lvr_host_s st_r;        // registered state
  lvr_host_s st_nxt;      // next state
  logic      acc;         // apb access phase
  logic [15:0] f;         // frame under build

  assign acc = psel && penable;

  // build frame and step state
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.req = 1'b0;
    f          = '0;
    f[CMD_BIT] = pwdata[CMD_BIT];
    f[ADDR_LSB +: ADDR_W] = pwdata[ADDR_LSB +: ADDR_W];
    if (pwdata[CMD_BIT])
    begin
      f[DATA_W-1:0] = pwdata[DATA_W-1:0];
    end
    f[PAR_BIT] = lvr_parity(f);
    unique case (st_r.fsm)
      HS_IDLE:
      begin
        // control write launches one frame
        if (acc && pwrite && paddr == HOST_CTRL)
        begin
          st_nxt.req   = 1'b1;
          st_nxt.frame = f;
          st_nxt.fsm   = HS_WAIT;
        end
      end
      HS_WAIT:
      begin
        if (link.rsp)
        begin
          st_nxt.rword = link.rdata;
          st_nxt.fsm   = HS_IDLE;
        end
      end
    endcase
    // apb read data, snapshot at the setup edge so prdata comes from a flip-flop;
    // the busy bit is therefore one cycle old, which polling software tolerates
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        HOST_CTRL:  st_nxt.prd = {16'h0000, st_r.frame};
        HOST_STAT:  st_nxt.prd = {31'h0000_0000, st_r.fsm == HS_WAIT};
        HOST_RDATA: st_nxt.prd = {16'h0000, st_r.rword};
        default:    st_nxt.prd = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r       <= '0;
      st_r.fsm   <= HS_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // zero-wait apb; read data is the registered setup-phase snapshot
  always_comb
  begin
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = st_r.prd;
  end

  assign link.req   = st_r.req;
  assign link.frame = st_r.frame;
endmodule : lvr_host
